// ===== rtl/sd_seq_consts.vh
// Constants of the sigma-delta conversion sequencer
`ifndef SD_SEQ_CONSTS_VH
`define SD_SEQ_CONSTS_VH
// Register indices (paddr[4:2]; byte offset is four times the index)
`define REG_COMM 3'h0
`define REG_SETUP 3'h1
`define REG_CLOCK 3'h2
`define REG_DATA 3'h3
`define REG_OFFSET 3'h4
`define REG_GAIN 3'h5
// Communications register fields
`define COMM_CHAN 0
`define COMM_PD 2
`define COMM_RDIR 3
`define COMM_TGT_LO 4
`define COMM_TGT_HI 6
`define COMM_READY 7
// Setup register fields
`define SETUP_OP_LO 0
`define SETUP_OP_HI 1
`define SETUP_HOLD 2
`define SETUP_GAIN_LO 3
`define SETUP_GAIN_HI 5
// Clock register fields
`define CLK_RATE_LO 0
`define CLK_RATE_HI 1
`define CLK_RANGE 2
`define CLK_HALVE 3
// Reset values
`define RST_RATE_CODE 2'h1
`define RST_RANGE 1'h1
`define RST_HOLD 1'h1
// Operation select codes
`define OP_NORMAL 2'h0
`define OP_SELF 2'h1
`define OP_ZERO_SYS 2'h2
`define OP_FULL_SYS 2'h3
// Decimation ratios, range 0 then range 1
`define DEC0_00 16'd391
`define DEC0_01 16'd313
`define DEC0_10 16'd78
`define DEC0_11 16'd39
`define DEC1_00 16'd384
`define DEC1_01 16'd320
`define DEC1_10 16'd77
`define DEC1_11 16'd38
`define MOD_RATIO 16'd128
// Counts in output periods
`define PER_NORMAL 4'd3
`define PER_SELF_READY 4'd9
`define PER_SYS_READY 4'd4
`define PER_SELF_DONE 4'd6
`define PER_SYS_DONE 4'd3
`define PER_SELF_ZERO 4'd3
// Counts in oscillator periods
`define PIPE_TICKS 16'd2000
`define BLANK_TICKS 16'd500
`endif

// ===== rtl/sigma_delta_conversion_sequencer.v
// Sequencer, APB registers and calibration store of a two-channel sigma-delta converter
// What this block does
// [R1] Range 0 decimations 391, 313, 78, 39
// [R2] Range 1 decimations 384, 320, 77, 38
// [R3] Period is 128 times decimation, doubled when halve_q is set
// [R4] Reset: defaults, ready high, bus ignored
// [R5] After reset wait for configuration first
// [R6] Oscillator output keeps running during reset
// [R7] Comm write picks channel, direction, target, powerdown
// [R8] Host names register before each access
// [R9] Hold resets filter; release starts work
// [R10] Hold low: result updates every period
// [R11] Ready shows as status bit and pin
// [R12] Normal: ready three periods after release
// [R13] Result read raises ready; rereads allowed
// [R14] Unread result: ready high 500 ticks
// [R15] Hold rising keeps unread ready low
// [R16] Calibration adds 2000-tick pipeline delay
// [R17] Self-calibration ready after nine periods
// [R18] System calibration ready after four periods
// [R19] Mode bits clear after six or three
// [R20] Codes 01,10,11 start the calibrations
// [R21] Host sets hold before calibration command
// [R22] Coefficients stored per channel automatically
// [R23] Self-calibration shorts inputs for zero scale
// [R24] Reset rate code 01, range select 1
// [R25] Mode returns to normal after calibration
// [R26] Hold release restarts the sequencer counters, not the oscillator or tick halver
//
// Implementation choices: the placing of the registers and register access over APB.
`include "sd_seq_consts.vh"
module sigma_delta_conversion_sequencer #(
   parameter OSC_HALF = 25
) (
   input wire clock,
   input wire rst,
   input wire porRst,
   input wire clockEn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output wire pready,
   output wire pslverr,
   input wire [15:0] convData,
   input wire [23:0] calOffsetIn,
   input wire [23:0] calGainIn,
   output reg bufferedOscOutput,
   output reg resultValidFlagN,
   output wire filterReset,
   output wire shortInputs,
   output wire powerDown,
   output wire calChannel,
   output wire [2:0] gainSelect
);
   localparam [3:0] S_IDLE = 4'h1;
   localparam [3:0] S_SETTLE = 4'h2;
   localparam [3:0] S_PIPE = 4'h4;
   localparam [3:0] S_RUN = 4'h8;

   function [15:0] decim;
      input range;
      input [1:0] code;
      begin
         case ({range, code})
            3'h0: decim = `DEC0_00; // R1
            3'h1: decim = `DEC0_01;
            3'h2: decim = `DEC0_10;
            3'h3: decim = `DEC0_11;
            3'h4: decim = `DEC1_00; // R2
            3'h5: decim = `DEC1_01;
            3'h6: decim = `DEC1_10;
            default: decim = `DEC1_11;
         endcase
      end
   endfunction

   function [15:0] periodTicks;
      input range;
      input [1:0] code;
      reg [31:0] prod;
      begin
         prod = `MOD_RATIO * decim(range, code); // R3
         periodTicks = prod[15:0];
      end
   endfunction

   function [15:0] countStep;
      input [15:0] cnt;
      input wrap;
      begin
         countStep = wrap ? 16'h0 : cnt + 16'h1;
      end
   endfunction

   // Oscillator divider, cleared only at power-on so reset pin never stops it
   reg [15:0] oscCnt_q;
   reg halfTog_q;
   wire oscWrap = (oscCnt_q == OSC_HALF[15:0] - 16'h1);
   // Tick marks one full oscillator period
   wire tick = clockEn & oscWrap & ~bufferedOscOutput;
   wire halve;
   wire rateTick = tick & (~halve | halfTog_q); // R3

   always @(posedge clock) begin
      if (porRst) begin
         oscCnt_q <= 16'h0;
         bufferedOscOutput <= 1'b0;
      end else if (clockEn) begin
         if (oscWrap) begin
            oscCnt_q <= 16'h0;
            bufferedOscOutput <= ~bufferedOscOutput; // R6
         end else begin
            oscCnt_q <= oscCnt_q + 16'h1;
         end
      end
   end

   // Halving stage of the rate tick; the reset pin restarts its phase
   always @(posedge clock) begin
      if (rst) begin
         halfTog_q <= 1'b0;
      end else if (tick) begin
         halfTog_q <= ~halfTog_q;
      end
   end

   // Registers
   reg [1:0] chan_q;
   reg pd_q;
   reg rdDir_q;
   reg [2:0] target_q;
   reg armed_q;
   reg [1:0] opSel_q;
   reg hold_q;
   reg [2:0] gain_q;
   reg configured_q;
   reg [1:0] rateCode_q;
   reg range_q;
   reg halve_q;
   reg [15:0] result_q;
   reg [23:0] offReg [0:1];
   reg [23:0] gainReg [0:1];
   reg [3:0] state_q;
   reg [15:0] periodCnt_q;
   reg [3:0] periods_q;
   reg [15:0] auxCnt_q;
   reg blank_q;
   reg [1:0] calKind_q;

   assign halve = halve_q;
   assign powerDown = pd_q;
   assign calChannel = chan_q[0];
   assign gainSelect = gain_q;
   // Filter stays parked until the first setup write after reset
   assign filterReset = rst | hold_q | ~configured_q; // R9

   // APB decode
   wire [2:0] idx = paddr[4:2];
   wire mapped = (paddr[7:5] == 3'h0) & (paddr[1:0] == 2'h0) & (idx <= `REG_GAIN);
   // Arming is spent by the first accepted non-COMM access after a comm write
   wire named = armed_q & (target_q == idx) & (pwrite == ~rdDir_q); // R8
   wire allowed = mapped & ((idx == `REG_COMM) | named);
   wire access = psel & penable & clockEn & ~rst; // R4
   assign pready = psel & penable & clockEn;
   // Refused accesses still end at once, so a host slip cannot stall the bus
   assign pslverr = pready & (rst | ~allowed);
   wire acc = access & allowed;
   wire commWr = acc & pwrite & (idx == `REG_COMM);
   wire setupWr = acc & pwrite & (idx == `REG_SETUP);
   wire clockWr = acc & pwrite & (idx == `REG_CLOCK);
   wire offWr = acc & pwrite & (idx == `REG_OFFSET);
   wire gainWr = acc & pwrite & (idx == `REG_GAIN);
   wire dataRd = acc & ~pwrite & (idx == `REG_DATA);

   wire newHold = pwdata[`SETUP_HOLD];
   wire [1:0] newOp = pwdata[`SETUP_OP_HI:`SETUP_OP_LO];
   // Release of hold, or calibration command with hold already low
   wire start = setupWr & ~newHold & (hold_q | (newOp != `OP_NORMAL) | ~configured_q); // R9
   wire holdRise = setupWr & newHold & ~hold_q;

   // Read data captured in the setup phase
   always @(posedge clock) begin
      if (rst) begin
         prdata <= 32'h0;
      end else if (clockEn & psel & ~penable) begin
         prdata <= 32'h0;
         if (allowed & ~pwrite) begin
            case (idx)
               `REG_COMM:
                  prdata <= {24'h0, resultValidFlagN, target_q, rdDir_q, pd_q, chan_q}; // R11
               `REG_SETUP:
                  prdata <= {26'h0, gain_q, hold_q, opSel_q};
               `REG_CLOCK:
                  prdata <= {28'h0, halve_q, range_q, rateCode_q};
               `REG_DATA:
                  prdata <= {16'h0, result_q}; // R13
               `REG_OFFSET:
                  prdata <= {8'h0, offReg[chan_q[0]]};
               `REG_GAIN:
                  prdata <= {8'h0, gainReg[chan_q[0]]};
               default:
                  prdata <= 32'h0;
            endcase
         end
      end
   end

   // Sequencer timing
   wire [15:0] perTicks = periodTicks(range_q, rateCode_q);
   wire periodEnd = rateTick & (periodCnt_q == perTicks - 16'h1);
   wire [3:0] periodsNext = periods_q + 4'h1;
   wire isSelf = (calKind_q == `OP_SELF);
   wire isNormal = (calKind_q == `OP_NORMAL);
   wire isSettle = (state_q == S_SETTLE);
   wire [3:0] readyN = isNormal ? `PER_NORMAL :
                       isSelf ? `PER_SELF_READY : `PER_SYS_READY; // R12 R17 R18
   wire [3:0] doneN = isSelf ? `PER_SELF_DONE : `PER_SYS_DONE;
   wire calDone = isSettle & periodEnd & ~isNormal & (periodsNext == doneN); // R19
   wire settleEnd = isSettle & periodEnd & (periodsNext == readyN);
   // Pipeline and blank spans count undivided ticks, unlike output periods
   wire pipeEnd = (state_q == S_PIPE) & tick & (auxCnt_q == `PIPE_TICKS - 16'h1); // R16
   wire newResult = (settleEnd & isNormal) | pipeEnd | ((state_q == S_RUN) & periodEnd); // R10
   wire blankEnd = blank_q & tick & (auxCnt_q == `BLANK_TICKS - 16'h1);

   // Inputs short only over the zero-scale part of self-calibration
   assign shortInputs = isSettle & isSelf & (periods_q < `PER_SELF_ZERO); // R23

   always @(posedge clock) begin
      if (rst) begin // R4
         chan_q <= 2'h0;
         pd_q <= 1'b0;
         rdDir_q <= 1'b0;
         target_q <= `REG_COMM; // R5
         armed_q <= 1'b0;
         opSel_q <= `OP_NORMAL;
         hold_q <= `RST_HOLD;
         gain_q <= 3'h0;
         configured_q <= 1'b0;
         rateCode_q <= `RST_RATE_CODE; // R24
         range_q <= `RST_RANGE; // R24
         halve_q <= 1'b0;
         result_q <= 16'h0;
         resultValidFlagN <= 1'b1; // R4
         state_q <= S_IDLE;
         periodCnt_q <= 16'h0;
         periods_q <= 4'h0;
         auxCnt_q <= 16'h0;
         blank_q <= 1'b0;
         calKind_q <= `OP_NORMAL;
         offReg[0] <= 24'h0;
         offReg[1] <= 24'h0;
         gainReg[0] <= 24'h0;
         gainReg[1] <= 24'h0;
      end else if (clockEn) begin
         if (commWr) begin // R7
            chan_q <= pwdata[`COMM_CHAN + 1:`COMM_CHAN];
            pd_q <= pwdata[`COMM_PD];
            rdDir_q <= pwdata[`COMM_RDIR];
            target_q <= pwdata[`COMM_TGT_HI:`COMM_TGT_LO];
            armed_q <= 1'b1;
         end else if (acc & (idx != `REG_COMM)) begin
            armed_q <= 1'b0; // R8
         end
         if (clockWr) begin
            rateCode_q <= pwdata[`CLK_RATE_HI:`CLK_RATE_LO];
            range_q <= pwdata[`CLK_RANGE];
            halve_q <= pwdata[`CLK_HALVE];
         end
         if (offWr) begin
            offReg[chan_q[0]] <= pwdata[23:0];
         end
         if (gainWr) begin
            gainReg[chan_q[0]] <= pwdata[23:0];
         end
         // Coefficients land in the calibrated channel's own pair
         if (calDone & ~start) begin
            if (calKind_q != `OP_FULL_SYS) begin
               offReg[chan_q[0]] <= calOffsetIn; // R22
            end
            if (calKind_q != `OP_ZERO_SYS) begin
               gainReg[chan_q[0]] <= calGainIn; // R22
            end
         end
         if (setupWr) begin
            hold_q <= newHold;
            gain_q <= pwdata[`SETUP_GAIN_HI:`SETUP_GAIN_LO];
            opSel_q <= newOp; // R20
            configured_q <= 1'b1; // R5
         end else if (calDone) begin
            opSel_q <= `OP_NORMAL; // R25
         end

         // Conversion state machine
         // Restart drops any partial conversion in progress
         if (start) begin // R26
            state_q <= S_SETTLE;
            calKind_q <= newOp; // R20
            periodCnt_q <= 16'h0;
            periods_q <= 4'h0;
            auxCnt_q <= 16'h0;
            blank_q <= 1'b0;
         end else if (holdRise) begin
            state_q <= S_IDLE; // R9 R15
            blank_q <= 1'b0;
         end else begin
            case (state_q)
               S_IDLE: begin
                  // Held at zero so a release times a whole period
                  periodCnt_q <= 16'h0;
               end
               S_SETTLE: begin
                  if (rateTick) begin
                     periodCnt_q <= countStep(periodCnt_q, periodEnd);
                  end
                  if (periodEnd) begin
                     periods_q <= periodsNext;
                  end
                  if (settleEnd) begin
                     auxCnt_q <= 16'h0;
                     state_q <= (calKind_q == `OP_NORMAL) ? S_RUN : S_PIPE;
                  end
               end
               S_PIPE: begin
                  if (tick) begin
                     auxCnt_q <= auxCnt_q + 16'h1;
                  end
                  if (pipeEnd) begin
                     periodCnt_q <= 16'h0;
                     auxCnt_q <= 16'h0;
                     state_q <= S_RUN;
                  end
               end
               S_RUN: begin
                  if (rateTick) begin
                     periodCnt_q <= countStep(periodCnt_q, periodEnd);
                  end
                  if (periodEnd) begin
                     auxCnt_q <= 16'h0;
                     blank_q <= ~resultValidFlagN & ~dataRd; // R14
                  end else if (blankEnd) begin
                     blank_q <= 1'b0;
                  end else if (blank_q & tick) begin
                     auxCnt_q <= auxCnt_q + 16'h1;
                  end
               end
               default: begin
                  state_q <= S_IDLE;
               end
            endcase
         end

         // A restart in the same cycle drops the finished word
         if (newResult & ~start) begin
            result_q <= convData; // R10
         end

         // Ready flag: a new result beats a read in the same cycle
         if (start) begin
            resultValidFlagN <= 1'b1; // R17
         end else if (newResult) begin
            // Unread result blanks the flag before it falls again
            resultValidFlagN <= (state_q == S_RUN) & ~resultValidFlagN & ~dataRd; // R14
         end else if (blankEnd & ~holdRise) begin
            resultValidFlagN <= 1'b0; // R14
         end else if (dataRd) begin
            resultValidFlagN <= 1'b1; // R13
         end
         // Hold rising, unless a period ends in that cycle, leaves an unread flag low until read or restart
      end
   end
endmodule

// ===== testbench/seq_asserts.sv
// Port-level checks of the conversion sequencer
module seq_asserts #(
   parameter OSC_HALF = 25
) (
   input logic clock,
   input logic rst,
   input logic porRst,
   input logic clockEn,
   input logic psel,
   input logic penable,
   input logic pwrite,
   input logic [7:0] paddr,
   input logic [31:0] pwdata,
   input logic pready,
   input logic pslverr,
   input logic bufferedOscOutput,
   input logic resultValidFlagN,
   input logic filterReset,
   input logic shortInputs,
   input logic powerDown,
   input logic calChannel
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clock);
   endclocking
   logic lastOsc_q;
   logic [15:0] oscAge_q;
   // Edges since the oscillator output last moved; frozen with clockEn
   always @(posedge clock) begin
      // Release of power-on reset counts as a fresh edge
      lastOsc_q <= porRst ? ~bufferedOscOutput : bufferedOscOutput;
      if (porRst || bufferedOscOutput != lastOsc_q) oscAge_q <= 16'h0;
      else if (clockEn) oscAge_q <= oscAge_q + 16'h1;
   end
   sequence dataRead;
      psel && penable && pready && !pwrite && paddr == 8'h0c && !pslverr;
   endsequence
   sequence commWrite;
      psel && penable && pready && pwrite && paddr == 8'h00;
   endsequence
   reset_ready_a: assert property (rst && clockEn |=> resultValidFlagN)
      else $error("ready not high in reset");
   reset_err_a: assert property (rst && psel && penable |-> pslverr)
      else $error("bus access not refused in reset");
   reset_filt_a: assert property (rst |-> filterReset)
      else $error("filter not held in reset");
   osc_run_a: assert property (disable iff (porRst) oscAge_q < OSC_HALF)
      else $error("oscillator output stalled");
   bus_ready_a: assert property (pready == (psel && penable && clockEn))
      else $error("pready wrong");
   unmapped_err_a: assert property (psel && penable && (paddr > 8'h14 || paddr[1:0] != 2'h0)
      |-> pslverr)
      else $error("unmapped access not refused");
   comm_write_a: assert property (disable iff (rst) commWrite |=>
      powerDown == $past(pwdata[2]) && calChannel == $past(pwdata[0]))
      else $error("comm write not applied");
   read_clear_a: assert property (disable iff (rst) dataRead |=> resultValidFlagN)
      else $error("ready not raised by result read");
   ready_fall_a: assert property (disable iff (rst)
      $fell(resultValidFlagN) |-> !$past(filterReset))
      else $error("result produced while filter held");
   hold_keep_a: assert property (disable iff (rst)
      filterReset && !resultValidFlagN && !(psel && penable) |=> !resultValidFlagN)
      else $error("unread ready lost under hold");
   cal_short_a: assert property (rst |=> !shortInputs)
      else $error("inputs shorted after reset");
endmodule

// ===== testbench/filter_datapath_model.sv
// Behavioural filter and calibration datapath feeding the sequencer
module filter_datapath_model (
   input logic clock,
   input logic filterReset,
   output logic [15:0] convData,
   output logic [23:0] calOffsetIn,
   output logic [23:0] calGainIn
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] churn_q = 16'h0;
   always @(posedge clock) churn_q <= churn_q + 16'h1;
   // A filter in reset has no stable word, so sampling it then shows garbage
   assign convData = filterReset ? ~churn_q : 16'ha5c3;
   assign calOffsetIn = 24'h3c5a71;
   assign calGainIn = 24'h61e2b4;
endmodule

// ===== testbench/tb.sv
// Register-level tests of the conversion sequencer
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int OH = 1;
   localparam int P = 128 * 38 * 2 * OH;
   logic clock, rst, porRst, clockEn, psel, penable, pwrite, pready, pslverr, err;
   logic bufferedOscOutput, resultValidFlagN, filterReset, shortInputs, powerDown, calChannel;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [2:0] gainSelect;
   logic [15:0] convData;
   logic [23:0] calOffsetIn, calGainIn;
   int miscompares = 0;
   int testsRun = 0;
   int n;
   sigma_delta_conversion_sequencer #(.OSC_HALF(OH)) u_sigma_delta_conversion_sequencer (
      .clock(clock), .rst(rst), .porRst(porRst), .clockEn(clockEn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .convData(convData), .calOffsetIn(calOffsetIn),
      .calGainIn(calGainIn), .bufferedOscOutput(bufferedOscOutput),
      .resultValidFlagN(resultValidFlagN), .filterReset(filterReset),
      .shortInputs(shortInputs), .powerDown(powerDown), .calChannel(calChannel),
      .gainSelect(gainSelect));
   filter_datapath_model u_filter_datapath_model (.clock(clock), .filterReset(filterReset),
      .convData(convData), .calOffsetIn(calOffsetIn), .calGainIn(calGainIn));
   initial begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      testsRun++;
      if (seen !== exp) begin
         miscompares++;
         $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
      end
   endtask
   task automatic close_out;
      if (miscompares == 0 && testsRun > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      // Only the watchdog ends a wait that never sees pready
      do begin
         @(posedge clock);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // Every access other than COMM must be named first, channel 1 throughout
   task automatic rdReg(input logic [2:0] r);
      apb(1'b1, 8'h00, {24'h0, 1'b0, r, 1'b1, 3'h1});
      apb(1'b0, {3'h0, r, 2'h0}, 32'h0);
   endtask
   task automatic wrReg(input logic [2:0] r, input logic [31:0] d);
      apb(1'b1, 8'h00, {24'h0, 1'b0, r, 1'b0, 3'h1});
      apb(1'b1, {3'h0, r, 2'h0}, d);
   endtask
   task automatic waitLvl(input logic lvl);
      n = 0;
      while (resultValidFlagN !== lvl && n < 200000) begin
         @(posedge clock);
         n++;
      end
   endtask
   // Phase of the tick divider allows a few clocks of slack
   function automatic logic [31:0] near(input int v, input int e);
      return {31'h0, v >= e - 8 && v <= e + 8};
   endfunction
   initial begin
      rst = 1'b1;
      porRst = 1'b1;
      clockEn = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h0;
      pwdata = 32'h0;
      repeat (12) @(posedge clock);
      rst <= 1'b0;
      porRst <= 1'b0;
      chk(resultValidFlagN, 32'h1);
      apb(1'b0, 8'h00, 32'h0);
      chk(rd[7], 32'h1);
      apb(1'b0, 8'h08, 32'h0);
      chk(err, 32'h1);
      rdReg(3'h2);
      chk(rd, 32'h5);
      rdReg(3'h1);
      chk(rd, 32'h4);
      apb(1'b0, 8'h1c, 32'h0);
      chk(err, 32'h1);
      apb(1'b1, 8'h06, 32'h0);
      chk(err, 32'h1);
      wrReg(3'h2, 32'h7);
      wrReg(3'h1, 32'h0);
      waitLvl(1'b0);
      chk(near(n, 3 * P), 32'h1);
      apb(1'b0, 8'h00, 32'h0);
      chk(rd[7], 32'h0);
      waitLvl(1'b1);
      waitLvl(1'b0);
      chk(near(n, 1000 * OH), 32'h1);
      wrReg(3'h1, 32'h4);
      repeat (20) @(posedge clock);
      chk(resultValidFlagN, 32'h0);
      rdReg(3'h3);
      chk(rd, 32'ha5c3);
      @(posedge clock);
      chk(resultValidFlagN, 32'h1);
      rdReg(3'h3);
      chk(rd, 32'ha5c3);
      wrReg(3'h1, 32'h2);
      waitLvl(1'b0);
      chk(near(n, 4 * P + 4000 * OH), 32'h1);
      rdReg(3'h1);
      chk(rd, 32'h0);
      rdReg(3'h4);
      chk(rd, 32'h3c5a71);
      chk(calChannel, 32'h1);
      wrReg(3'h1, 32'h4);
      wrReg(3'h1, 32'h1);
      repeat (4) @(posedge clock);
      chk(shortInputs, 32'h1);
      chk(resultValidFlagN, 32'h1);
      wrReg(3'h1, 32'h4);
      wrReg(3'h1, 32'h3);
      rdReg(3'h1);
      chk(rd, 32'h3);
      chk(shortInputs, 32'h0);
      close_out;
   end
   initial begin
      repeat (95000) @(posedge clock);
      miscompares++;
      close_out;
   end
endmodule
bind sigma_delta_conversion_sequencer seq_asserts #(.OSC_HALF(OSC_HALF)) u_seq_asserts (
   .clock(clock), .rst(rst), .porRst(porRst), .clockEn(clockEn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
   .pslverr(pslverr), .bufferedOscOutput(bufferedOscOutput),
   .resultValidFlagN(resultValidFlagN), .filterReset(filterReset),
   .shortInputs(shortInputs), .powerDown(powerDown), .calChannel(calChannel));
